// ### pcm_pkg.sv
// Shared constants and carrier types for the pad configuration block
package pcm_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFF_PADS_8_11 = 8'h08;
	localparam logic [7:0] OFF_PADS_12_15 = 8'h0C;
	localparam logic [7:0] OFF_PADS_16_19 = 8'h10;
	localparam logic [7:0] OFF_UNLOCK_KEY = 8'h20;

	// Unlock value, arbitrary
	localparam logic [31:0] UNLOCK_VALUE = 32'h0000_0073;

	////////////////////////////////////////////////////////////////////////
	// Field positions inside one eight-bit pad slot, PWRDN_POS counted in the whole word
	localparam int SLOT_W = 8;
	localparam int PULL_POS = 0;
	localparam int INPEN_POS = 1;
	localparam int STRNG_POS = 2;
	localparam int FSEL_POS = 3;
	localparam int RSEL_POS = 6;
	localparam int PWRDN_POS = 30;
	localparam int NUM_PADS = 12;
	localparam int PADS_PER_REG = 4;

	// Writable bits of each register, reserved bits stay zero
	localparam logic [31:0] MASK_PADS_8_11 = 32'h5F3F_FFFF;
	localparam logic [31:0] MASK_PADS_12_15 = 32'h3F3F_3F1F;
	localparam logic [31:0] MASK_PADS_16_19 = 32'h1F1F_3F1F;

	// Reset values: every selector at GPIO, all else off
	localparam logic [31:0] RST_PADS_8_11 = 32'h1818_1818;
	localparam logic [31:0] RST_PADS_12_15 = 32'h1818_1818;
	localparam logic [31:0] RST_PADS_16_19 = 32'h1818_1818;
	localparam logic [2:0] FSEL_GPIO = 3'h3;

	////////////////////////////////////////////////////////////////////////
	// Selector codes that connect a function, one bit per code
	localparam logic [7:0] LISTED_P8 = 8'hAF;
	localparam logic [7:0] LISTED_P9 = 8'hAF;
	localparam logic [7:0] LISTED_P10 = 8'h8F;
	localparam logic [7:0] LISTED_P11 = 8'h0F;
	localparam logic [7:0] LISTED_P12 = 8'h0F;
	localparam logic [7:0] LISTED_P13 = 8'h4F;
	localparam logic [7:0] LISTED_P14 = 8'h0F;
	localparam logic [7:0] LISTED_P15 = 8'h0F;
	localparam logic [7:0] LISTED_P16 = 8'h0F;
	localparam logic [7:0] LISTED_P17 = 8'h0F;
	localparam logic [7:0] LISTED_P18 = 8'h0F;
	localparam logic [7:0] LISTED_P19 = 8'h0F;
	localparam logic [95:0] LISTED_ALL = {LISTED_P19, LISTED_P18, LISTED_P17,
		LISTED_P16, LISTED_P15, LISTED_P14, LISTED_P13, LISTED_P12,
		LISTED_P11, LISTED_P10, LISTED_P9, LISTED_P8};

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// Pad settings handed to the pad ring, index 0 is pad 8
	typedef struct packed {
		logic [11:0][2:0] fsel;
		logic [11:0] func_en;
		logic [11:0] strength;
		logic [11:0] input_en;
		logic [11:0] pullup_en;
		logic [1:0][1:0] pullup_value;
		logic pad11_power_switch;
	} pcm_pad_cfg_type;

	// Whole state of the block
	typedef struct packed {
		logic [31:0] pad_c;
		logic [31:0] pad_d;
		logic [31:0] pad_e;
		logic unlocked;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		pcm_pad_cfg_type cfg;
	} pcm_state_type;
endpackage : pcm_pkg

// ### pcm_pad_mux_top.sv
// Pad configuration and function select for pads 8 to 19 behind AXI4-Lite
// Contract
// - Pad 11 selector: analog test, chip select 0, clock out, GPIO; reset GPIO.
// - Every pad has a drive strength bit, 1 is high, reset low.
// - Every pad has an input enable bit, 1 enables, reset disabled.
// - Every pad has a pull-up enable bit, 1 on, reset off.
// - Pad 10 selector codes 0-3 and 7 connect, code 6 disables.
// - Pads 8 and 9 carry two-bit pull-up value fields resetting to 0.
// - Pad 9 selector codes 0-3, 5, 7 connect, code 6 disables.
// - Pad 8 selector codes 0-3, 5, 7 connect, code 6 disables.
// - Pad 15 selector codes 0-3 connect, code 7 disables.
// - Pad 14 selector codes 0-3 connect, code 7 disables.
// - Pad 13 selector codes 0-3 and 6 connect, code 7 disables.
// - Pad 12 two-bit selector codes 0-3 all connect.
// - Pad 19 two-bit selector codes 0-3 all connect.
// - Pad 18 two-bit selector codes 0-3 all connect.
// - Pad 17 selector codes 0-3 connect, code 7 disables.
// - Pad register writes are ignored until software unlocks them by key.
// - Offset 0xC holds pads 15 to 12, one byte per pad.
// - Offset 0x10 holds pads 19 to 16 in the same layout.
`timescale 1ns/1ns
module pcm_pad_mux_top (
	input wire logic i_core_clk, // Core clock, 125 MHz
	input wire logic i_resetn, // Asynchronous reset, active low
	input wire logic i_s_axi_awvalid, // Write address valid
	output logic o_s_axi_awready, // Write address ready
	input wire logic [7:0] i_s_axi_awaddr, // Write byte address
	input wire logic i_s_axi_wvalid, // Write data valid
	output logic o_s_axi_wready, // Write data ready
	input wire logic [31:0] i_s_axi_wdata, // Write data
	input wire logic [3:0] i_s_axi_wstrb, // Write byte strobes
	output logic o_s_axi_bvalid, // Write response valid
	input wire logic i_s_axi_bready, // Write response ready
	output logic [1:0] o_s_axi_bresp, // Write response code
	input wire logic i_s_axi_arvalid, // Read address valid
	output logic o_s_axi_arready, // Read address ready
	input wire logic [7:0] i_s_axi_araddr, // Read byte address
	output logic o_s_axi_rvalid, // Read data valid
	input wire logic i_s_axi_rready, // Read data ready
	output logic [31:0] o_s_axi_rdata, // Read data
	output logic [1:0] o_s_axi_rresp, // Read response code
	output pcm_pkg::pcm_pad_cfg_type o_pad_cfg, // Settings to the pad ring
	output logic o_pads_unlocked // Pad registers open for writes
);
	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops
	logic [1:0] rst_sync_r;
	logic rst_n;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'h1};
		end
	end

	assign rst_n = rst_sync_r[1];

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Byte strobes widened to a bit mask
	function automatic logic [31:0] strb_bits(input logic [3:0] s);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		return m;
	endfunction : strb_bits

	// Strobed merge, reserved bits forced to zero
	function automatic logic [31:0] merge_word(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] s, input logic [31:0] keep);
		logic [31:0] m;
		m = strb_bits(s);
		return ((old & ~m) | (wd & m)) & keep;
	endfunction : merge_word

	// Register words unpacked into per-pad settings
	function automatic pcm_pkg::pcm_pad_cfg_type decode_pads(input logic [31:0] c,
		input logic [31:0] d, input logic [31:0] e);
		pcm_pkg::pcm_pad_cfg_type f;
		logic [31:0] src;
		logic [2:0] code;
		int base;
		f = '0;
		src = c;
		code = 3'h0;
		base = 0;
		for (int p = 0; p < pcm_pkg::NUM_PADS; p++) begin
			if (p < pcm_pkg::PADS_PER_REG) begin
				src = c;
			end else if (p < 2 * pcm_pkg::PADS_PER_REG) begin
				src = d;
			end else begin
				src = e;
			end
			base = (p % pcm_pkg::PADS_PER_REG) * pcm_pkg::SLOT_W;
			code = src[base + pcm_pkg::FSEL_POS +: 3];
			f.fsel[p] = code;
			f.func_en[p] = pcm_pkg::LISTED_ALL[p * 8 + int'(code)];
			f.strength[p] = src[base + pcm_pkg::STRNG_POS];
			f.input_en[p] = src[base + pcm_pkg::INPEN_POS];
			f.pullup_en[p] = src[base + pcm_pkg::PULL_POS];
		end
		f.pullup_value[0] = c[pcm_pkg::RSEL_POS +: 2];
		f.pullup_value[1] = c[pcm_pkg::SLOT_W + pcm_pkg::RSEL_POS +: 2];
		f.pad11_power_switch = c[pcm_pkg::PWRDN_POS];
		return f;
	endfunction : decode_pads

	////////////////////////////////////////////////////////////////////////
	// State
	pcm_pkg::pcm_state_type r;
	pcm_pkg::pcm_state_type n;
	logic wr_fire;
	logic [31:0] rd_word;
	logic rd_hit;

	// Both halves of a write held and no answer pending
	assign wr_fire = r.aw_held && r.w_held && !r.bvalid;

	// Handshake outputs
	assign o_s_axi_awready = !r.aw_held && !r.bvalid;
	assign o_s_axi_wready = !r.w_held && !r.bvalid;
	assign o_s_axi_arready = !r.rvalid;

	// Registered data outputs
	assign o_s_axi_bvalid = r.bvalid;
	assign o_s_axi_bresp = r.bresp;
	assign o_s_axi_rvalid = r.rvalid;
	assign o_s_axi_rdata = r.rdata;
	assign o_s_axi_rresp = r.rresp;
	assign o_pad_cfg = r.cfg;
	assign o_pads_unlocked = r.unlocked;

	// Read address decode
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'h1;
		case (i_s_axi_araddr)
			pcm_pkg::OFF_PADS_8_11: rd_word = r.pad_c;
			pcm_pkg::OFF_PADS_12_15: rd_word = r.pad_d;
			pcm_pkg::OFF_PADS_16_19: rd_word = r.pad_e;
			pcm_pkg::OFF_UNLOCK_KEY: rd_word = {31'h0000_0000, r.unlocked};
			default: rd_hit = 1'h0;
		endcase
	end

	// Next state
	always_comb begin
		n = r;
		// Address and data taken in either order
		if (i_s_axi_awvalid && o_s_axi_awready) begin
			n.aw_held = 1'h1;
			n.aw_addr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && o_s_axi_wready) begin
			n.w_held = 1'h1;
			n.w_data = i_s_axi_wdata;
			n.w_strb = i_s_axi_wstrb;
		end
		if (r.bvalid && i_s_axi_bready) begin
			n.bvalid = 1'h0;
		end
		// Perform a write once both halves are in
		if (wr_fire) begin
			n.aw_held = 1'h0;
			n.w_held = 1'h0;
			n.bvalid = 1'h1;
			n.bresp = pcm_pkg::RESP_OKAY;
			case (r.aw_addr)
				pcm_pkg::OFF_PADS_8_11: begin
					if (r.unlocked) begin
						n.pad_c = merge_word(r.pad_c, r.w_data, r.w_strb,
							pcm_pkg::MASK_PADS_8_11);
					end
				end
				pcm_pkg::OFF_PADS_12_15: begin
					if (r.unlocked) begin
						n.pad_d = merge_word(r.pad_d, r.w_data, r.w_strb,
							pcm_pkg::MASK_PADS_12_15);
					end
				end
				pcm_pkg::OFF_PADS_16_19: begin
					if (r.unlocked) begin
						n.pad_e = merge_word(r.pad_e, r.w_data, r.w_strb,
							pcm_pkg::MASK_PADS_16_19);
					end
				end
				pcm_pkg::OFF_UNLOCK_KEY: begin
					// Full-word key opens, anything else closes
					n.unlocked = (r.w_data == pcm_pkg::UNLOCK_VALUE)
						&& (r.w_strb == 4'hF);
				end
				default: n.bresp = pcm_pkg::RESP_SLVERR;
			endcase
		end
		// Read answer
		if (r.rvalid && i_s_axi_rready) begin
			n.rvalid = 1'h0;
		end
		if (i_s_axi_arvalid && o_s_axi_arready) begin
			n.rvalid = 1'h1;
			n.rdata = rd_word;
			n.rresp = rd_hit ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
		end
		n.cfg = decode_pads(n.pad_c, n.pad_d, n.pad_e);
	end

	// State register
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.pad_c <= pcm_pkg::RST_PADS_8_11;
			r.pad_d <= pcm_pkg::RST_PADS_12_15;
			r.pad_e <= pcm_pkg::RST_PADS_16_19;
			r.cfg <= decode_pads(pcm_pkg::RST_PADS_8_11, pcm_pkg::RST_PADS_12_15,
				pcm_pkg::RST_PADS_16_19);
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!rst_n);

	// Write halves both present
	sequence s_write_ready;
		wr_fire;
	endsequence

	// Response raised after a write
	sequence s_write_answered;
		##1 o_s_axi_bvalid;
	endsequence

	chk_write_answer:
	assert property (s_write_ready |-> s_write_answered)
		else $error("write not answered next cycle");

	chk_pad11_reset:
	assert property ($rose(rst_n) |-> r.cfg.fsel[3] == pcm_pkg::FSEL_GPIO
		&& r.cfg.func_en[3])
		else $error("pad 11 selector not at GPIO after reset");

	chk_strength_reset:
	assert property ($rose(rst_n) |-> r.cfg.strength == 12'h000)
		else $error("drive strength not low after reset");

	chk_input_reset:
	assert property ($rose(rst_n) |-> r.cfg.input_en == 12'h000)
		else $error("input enable not off after reset");

	chk_pullup_reset:
	assert property ($rose(rst_n) |-> r.cfg.pullup_en == 12'h000
		&& r.cfg.pullup_value == 4'h0)
		else $error("pull-up settings not off after reset");

	chk_pad10_disable:
	assert property (r.cfg.fsel[2] == 3'h6 |-> !r.cfg.func_en[2])
		else $error("pad 10 disabled code left a function on");

	chk_pad9_codes:
	assert property (r.cfg.fsel[1] == 3'h4 |-> !r.cfg.func_en[1]
		|| (r.cfg.fsel[1] == 3'h5 && r.cfg.func_en[1]))
		else $error("pad 9 selector decode wrong");

	chk_pad8_loopback:
	assert property (r.cfg.fsel[0] == 3'h5 || r.cfg.fsel[0] == 3'h7 |-> r.cfg.func_en[0])
		else $error("pad 8 loopback code not connected");

	chk_pad13_trace:
	assert property (r.cfg.fsel[5] == 3'h6 |-> r.cfg.func_en[5])
		else $error("pad 13 trace code not connected");

	chk_pad15_disable:
	assert property (r.cfg.fsel[7] == 3'h7 |-> !r.cfg.func_en[7])
		else $error("pad 15 disabled code left a function on");

	chk_locked_write_ignored:
	assert property (wr_fire && !r.unlocked
		&& r.aw_addr == pcm_pkg::OFF_PADS_8_11 |=> $stable(r.pad_c))
		else $error("locked write changed pad register");

	chk_offset_c_read:
	assert property (i_s_axi_arvalid && o_s_axi_arready
		&& i_s_axi_araddr == pcm_pkg::OFF_PADS_12_15
		|=> o_s_axi_rvalid && o_s_axi_rdata == $past(r.pad_d))
		else $error("read of pads 12 to 15 returned wrong word");

	chk_offset_10_write:
	assert property (wr_fire && r.unlocked && r.w_strb == 4'hF
		&& r.aw_addr == pcm_pkg::OFF_PADS_16_19
		|=> r.pad_e == ($past(r.w_data) & pcm_pkg::MASK_PADS_16_19))
		else $error("unlocked write to pads 16 to 19 lost");

	chk_reserved_zero:
	assert property (((r.pad_c & ~pcm_pkg::MASK_PADS_8_11)
		| (r.pad_d & ~pcm_pkg::MASK_PADS_12_15)
		| (r.pad_e & ~pcm_pkg::MASK_PADS_16_19)) == 32'h0000_0000)
		else $error("reserved bit set");
endmodule : pcm_pad_mux_top

// ### pcm_pad_ring_model.sv
// Behavioural pad ring that observes the settings the block hands it
`timescale 1ns/1ns
module pcm_pad_ring_model (
	input wire pcm_pkg::pcm_pad_cfg_type i_pad_cfg, // Settings from the block
	output logic [11:0] o_live, // Pads with a peripheral connected
	output logic [11:0] o_rx_on // Pad input receivers switched on
);
	// A pad carries a function only for a listed selector code
	assign o_live = i_pad_cfg.func_en;
	// Receiver power follows the input enable bit
	assign o_rx_on = i_pad_cfg.input_en;
endmodule : pcm_pad_ring_model

// ### tb.sv
// Self-checking bench for the pad configuration block
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic rstn;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, unl;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [11:0] live, rx_on;
	pcm_pkg::pcm_pad_cfg_type cfg;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	// Selector codes that connect a function, index 0 is pad 8
	localparam logic [7:0] LST [12] = '{8'hAF, 8'hAF, 8'h8F, 8'h0F, 8'h0F, 8'h4F,
		8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F};

	// 125 MHz clock
	always #4 clk = ~clk;

	pcm_pad_mux_top u_dut (.i_core_clk(clk), .i_resetn(rstn),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_pad_cfg(cfg),
		.o_pads_unlocked(unl));
	pcm_pad_ring_model u_ring (.i_pad_cfg(cfg), .o_live(live), .o_rx_on(rx_on));

	////////////////////////////////////////////////////////////////////////
	// Verdict and closing counts
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////////////
	// Bus master: hold each channel until taken, bready until the answer
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
		output logic [1:0] resp);
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic wrchk(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
		input logic [31:0] e);
		wr(a, v, s, r);
		chk(32'(r), 32'(pcm_pkg::RESP_OKAY));
		rd(a, d, r);
		chk(d, e);
	endtask : wrchk

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		rd(8'h08, d, r);
		chk(d, 32'h1818_1818);
		rd(8'h0C, d, r);
		chk(d, 32'h1818_1818);
		rd(8'h10, d, r);
		chk(d, 32'h1818_1818);
		chk(32'(cfg.strength), 32'h0000_0000);
		chk(32'(rx_on), 32'h0000_0000);
		chk(32'(cfg.pullup_en), 32'h0000_0000);
		chk(32'(unl), 32'h0000_0000);
	endtask : t_reset

	task automatic t_locked;
		wrchk(8'h0C, 32'hFFFF_FFFF, 4'hF, 32'h1818_1818);
	endtask : t_locked

	task automatic t_full;
		wr(8'h20, pcm_pkg::UNLOCK_VALUE, 4'hF, r);
		chk(32'(unl), 32'h0000_0001);
		wrchk(8'h08, 32'hFFFF_FFFF, 4'hF, 32'h5F3F_FFFF);
		wrchk(8'h0C, 32'hFFFF_FFFF, 4'hF, 32'h3F3F_3F1F);
		wrchk(8'h10, 32'hFFFF_FFFF, 4'hF, 32'h1F1F_3F1F);
		chk(32'(cfg.strength), 32'h0000_0FFF);
		chk(32'(rx_on), 32'h0000_0FFF);
		chk(32'(cfg.pullup_en), 32'h0000_0FFF);
		chk(32'(cfg.pad11_power_switch), 32'h0000_0001);
		wrchk(8'h0C, 32'h0000_0000, 4'h1, 32'h3F3F_3F00);
	endtask : t_full

	task automatic t_pull;
		wrchk(8'h08, 32'h1818_9858, 4'hF, 32'h1818_9858);
		chk(32'(cfg.pullup_value), 32'h0000_0009);
	endtask : t_pull

	task automatic t_codes;
		logic [31:0] v;
		logic [7:0] a;
		int n;
		for (int i = 0; i < 12; i++) begin
			n = (i == 3 || i == 4 || i == 8 || i > 9) ? 4 : 8;
			a = 8'h08 + 8'(4 * (i / 4));
			for (int c = 0; c < n; c++) begin
				v = 32'h1818_1818;
				v[8 * (i % 4) + 3 +: 3] = 3'(c);
				wrchk(a, v, 4'hF, v);
				chk(32'(cfg.fsel[i]), 32'(c));
				if (i < 3) chk(32'(live[i]), 32'(LST[i][c]));
				else chk(32'(live[i]), 32'(LST[i][c]));
			end
		end
	endtask : t_codes

	task automatic t_unmapped;
		wr(8'h04, 32'hFFFF_FFFF, 4'hF, r);
		chk(32'(r), 32'(pcm_pkg::RESP_SLVERR));
		rd(8'h30, d, r);
		chk(32'(r), 32'(pcm_pkg::RESP_SLVERR));
	endtask : t_unmapped

	task automatic t_relock;
		wr(8'h20, 32'h0000_0000, 4'hF, r);
		chk(32'(unl), 32'h0000_0000);
		wrchk(8'h08, 32'h0000_0000, 4'hF, 32'h1818_1818);
	endtask : t_relock

	// Main sequence, reset asserted at time zero so no check sees unknown state
	initial begin
		rstn <= 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_locked();
		t_full();
		t_pull();
		t_codes();
		t_unmapped();
		t_relock();
		end_of_test();
	end
endmodule : tb
